// ---- hdl/sfcp_command_port.v ----
// sfcp_command_port.v: telegram acknowledge, fieldbus process data,
// address keeping and first-come arbitration of the sensor port
// assumes words arrive already byte-assembled, low byte first on the wire
//
// Behaviour
// (RQ1) reply ffff ffff 4141, echo command, zero count
// (RQ2) host selects task with 004b, count two
// (RQ3) fieldbus slave, auto baud, up to 6 Mbit
// (RQ4) menu mode freezes process data, ignores requests; only fieldbus tasks are ignored, ethernet and pin tasks still load
// (RQ5) command mode freezes process data, ignores requests; only fieldbus tasks are ignored, ethernet and pin tasks still load
// (RQ6) config tool attached: refresh every 200 ms
// (RQ7) first arriving source wins, equal priority; same-cycle ties go ethernet, then fieldbus, then pins
// (RQ8) ethernet and fieldbus both live in detection
// (RQ9) fieldbus selects one of 16 tasks
// (RQ10) report windows, hits, logic, scan, status
// (RQ11) factory slave address is 126
// (RQ12) master assigns address below 126
// (RQ13) assigned address stored, readable, changeable later
// (RQ14) local address change takes effect after power-on
// (RQ15) control enables a described data module only
// (RQ16) unprocessable command answered with 414e
// (RQ17) telegram words are little-endian
// (RQ18) padding and unused reply fields are zero
`timescale 1ns/1ps
`default_nettype none
`include "sfcp_defs.vh"
module sfcp_command_port #(
   parameter SLOW_CYCLES = (`SFCP_SLOW_MS * `SFCP_CLK_KHZ)
) (
   // clock and reset
   input  wire        mclk,
   input  wire        reset_n,
   // received telegram words, little-endian assembled upstream
   input  wire        rxValid,
   input  wire [15:0] rxWord,
   input  wire        rxLast,
   // reply words
   output wire        txValid,
   input  wire        txReady,
   output wire [15:0] txWord,
   // fieldbus side (frames decoded by the bus engine)
   input  wire        fbBaudLock,
   input  wire        fbTaskStrobe,
   input  wire [3:0]  fbTaskNum,
   input  wire        fbAddrStrobe,
   input  wire [6:0]  fbAddrNew,
   // discrete task lines (asynchronous pins)
   input  wire        pinTaskStrobe,
   input  wire [3:0]  pinTaskNum,
   // sensor state
   input  wire [1:0]  sensorMode,
   input  wire        toolAttached,
   input  wire        scanDone,
   input  wire [15:0] scanNum,
   input  wire [7:0]  sensorInfo,
   input  wire [7:0]  sensorState,
   input  wire [15:0] awResult,
   input  wire [143:0] awHits,
   input  wire [7:0]  logicResult,
   // address storage
   input  wire [6:0]  nvAddr,
   input  wire        nvAddrValid,
   input  wire        localAddrStrobe,
   input  wire [6:0]  localAddr,
   output reg         nvWrite,
   output reg  [6:0]  nvWriteAddr,
   output reg  [6:0]  slaveAddr,
   // task selection and process data out
   output reg         taskLoad,
   output reg  [3:0]  taskSel,
   output reg         taskSave,
   output reg         fbActive,
   output reg  [207:0] procData
);
   localparam ST_HDR  = 2'h0;
   localparam ST_DATA = 2'h1;
   localparam ST_SEND = 2'h2;

   reg [1:0]  state_r;
   reg [3:0]  idx_r;
   reg [15:0] cmd_r;
   reg [15:0] cnt_r;
   reg [15:0] taskWord_r;
   reg [1:0]  dataIdx_r;
   reg        nak_r;
   reg [3:0]  txIdx_r;
   reg [31:0] slowCnt_r;
   reg        pinSync1_r;
   reg        pinSync2_r;
   reg [3:0]  pinTask1_r;
   reg [3:0]  pinTask2_r;
   reg        pinPrev_r;
   reg        addrLoaded_r;
   reg [15:0] bufWord;
   wire       bufReady;
   wire       frozen;
   wire       pinEdge;
   wire       ethTask;
   wire       slowTick;

   // menu and command modes hold process data and ignore fieldbus task requests
   assign frozen   = (sensorMode == `SFCP_MODE_MENU) ||
                     (sensorMode == `SFCP_MODE_CMD); // RQ4 RQ5
   assign pinEdge  = pinSync2_r & ~pinPrev_r;
   assign slowTick = (slowCnt_r == 32'h0);
   assign ethTask  = (state_r == ST_DATA) && rxValid && rxLast && !nak_r &&
                     (dataIdx_r == 2'h1) && (taskWord_r[15:4] == 12'h0); // RQ16

   ////////////////////////////////////////////////////////////////////////
   // pins pass two flops before any logic sees them
   always @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         pinSync1_r <= 1'b0;
         pinSync2_r <= 1'b0;
         pinTask1_r <= 4'h0;
         pinTask2_r <= 4'h0;
         pinPrev_r  <= 1'b0;
      end
      else
      begin
         pinSync1_r <= pinTaskStrobe;
         pinSync2_r <= pinSync1_r;
         pinTask1_r <= pinTaskNum;
         pinTask2_r <= pinTask1_r;
         pinPrev_r  <= pinSync2_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // telegram receive: header, optional user data, then reply
   always @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         state_r    <= ST_HDR;
         idx_r      <= 4'h0;
         cmd_r      <= 16'h0;
         cnt_r      <= 16'h0;
         taskWord_r <= 16'h0;
         dataIdx_r  <= 2'h0;
         nak_r      <= 1'b0;
         txIdx_r    <= 4'h0;
      end
      else
      begin
         case (state_r)
            ST_HDR:
               if (rxValid)
               begin
                  idx_r <= idx_r + 4'h1;
                  if (idx_r == `SFCP_IDX_CMD)
                     cmd_r <= rxWord;
                  if ((idx_r < 4'h2) && (rxWord != `SFCP_START_WORD))
                     nak_r <= 1'b1;
                  if (idx_r == `SFCP_IDX_COUNT)
                  begin
                     cnt_r     <= rxWord;
                     dataIdx_r <= 2'h0;
                     idx_r     <= 4'h0;
                     // only task select is executed here, with its fixed count
                     if (cmd_r != `SFCP_CMD_SET_TASK ||
                         rxWord != `SFCP_SET_TASK_CNT)
                        nak_r <= 1'b1; // RQ16
                     if (rxLast || rxWord == 16'h0)
                     begin
                        state_r <= ST_SEND;
                        txIdx_r <= 4'h0;
                     end
                     else
                        state_r <= ST_DATA;
                  end
               end
            ST_DATA:
               if (rxValid)
               begin
                  dataIdx_r <= dataIdx_r + 2'h1;
                  if (dataIdx_r == 2'h0)
                     taskWord_r <= rxWord; // RQ2
                  if (taskWord_r > 16'h000f && dataIdx_r == 2'h1)
                     nak_r <= 1'b1;
                  if (rxLast)
                  begin
                     state_r <= ST_SEND;
                     txIdx_r <= 4'h0;
                     if (dataIdx_r != 2'h1)
                        nak_r <= 1'b1; // RQ16
                  end
               end
            ST_SEND:
               if (bufReady)
               begin
                  txIdx_r <= txIdx_r + 4'h1;
                  if (txIdx_r == `SFCP_IDX_COUNT)
                  begin
                     state_r <= ST_HDR;
                     nak_r   <= 1'b0;
                  end
               end
            default:
               state_r <= ST_HDR;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // reply word mux; all other fields and padding are zero
   always @*
   begin
      bufWord = 16'h0; // RQ18
      if (txIdx_r < 4'h2)
         bufWord = `SFCP_START_WORD; // RQ1
      else if (txIdx_r == `SFCP_IDX_CMD)
         bufWord = nak_r ? `SFCP_CMD_NAK : `SFCP_CMD_ACK; // RQ1 RQ16
      else if (txIdx_r == `SFCP_IDX_TRANS)
         bufWord = cmd_r; // RQ1
   end

   sfcp_skid_buffer #(
      .WIDTH (16)
   ) u_buf (
      .mclk     (mclk),
      .reset_n  (reset_n),
      .inValid  (state_r == ST_SEND),
      .inReady  (bufReady),
      .inData   (bufWord),
      .outValid (txValid),
      .outReady (txReady),
      .outData  (txWord)   // RQ17 whole words; byte order set downstream
   );

   ////////////////////////////////////////////////////////////////////////
   // task select: the first source seen in a cycle wins, ties by order
   always @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         taskLoad <= 1'b0;
         taskSel  <= 4'h0;
         taskSave <= 1'b0;
      end
      else
      begin
         taskLoad <= 1'b0;
         if (ethTask) // RQ7 RQ8
         begin
            taskLoad <= 1'b1;
            taskSel  <= taskWord_r[3:0];
            taskSave <= rxWord[0];
         end
         else if (fbTaskStrobe && !frozen && (slowTick || !toolAttached))
         begin
            taskLoad <= 1'b1; // RQ9 RQ7
            taskSel  <= fbTaskNum;
            taskSave <= 1'b0;
         end
         else if (pinEdge)
         begin
            taskLoad <= 1'b1; // RQ7
            taskSel  <= pinTask2_r;
            taskSave <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // 200 ms divider paces refresh while the tool is attached
   always @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
         slowCnt_r <= 32'h0;
      else if (slowTick)
         slowCnt_r <= SLOW_CYCLES - 1; // RQ6
      else
         slowCnt_r <= slowCnt_r - 32'h1;
   end

   ////////////////////////////////////////////////////////////////////////
   // process image; frozen in menu/command mode, slowed with the tool
   always @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         procData <= 208'h0;
         fbActive <= 1'b0;
      end
      else
      begin
         fbActive <= fbBaudLock; // RQ3
         if (scanDone && !frozen && (!toolAttached || slowTick)) // RQ4 RQ5 RQ6
            procData <= {scanNum, sensorInfo, sensorState, awResult,
                         awHits, logicResult, 8'h0}; // RQ10
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // slave address: factory 126, master assignment stored at once,
   // local changes only stored and picked up after the next power-on
   always @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         slaveAddr    <= `SFCP_ADDR_DEFAULT; // RQ11
         addrLoaded_r <= 1'b0;
         nvWrite      <= 1'b0;
         nvWriteAddr  <= `SFCP_ADDR_DEFAULT;
      end
      else
      begin
         nvWrite <= 1'b0;
         if (!addrLoaded_r)
         begin
            addrLoaded_r <= 1'b1;
            if (nvAddrValid)
               slaveAddr <= nvAddr; // RQ14
         end
         else if (fbAddrStrobe && slaveAddr == `SFCP_ADDR_DEFAULT &&
                  fbAddrNew < `SFCP_ADDR_DEFAULT) // RQ12
         begin
            slaveAddr   <= fbAddrNew;
            nvWrite     <= 1'b1; // RQ13
            nvWriteAddr <= fbAddrNew;
         end
         else if (localAddrStrobe)
         begin
            nvWrite     <= 1'b1; // RQ13 RQ14
            nvWriteAddr <= localAddr;
         end
      end
   end
endmodule // sfcp_command_port
`default_nettype wire

// ---- hdl/sfcp_defs.vh ----
// sfcp_defs.vh: constants of the sensor fieldbus command port
// assumes plain verilog-2005 inclusion by bare name
`ifndef SFCP_DEFS_VH
`define SFCP_DEFS_VH
// telegram words
`define SFCP_START_WORD    16'hffff
`define SFCP_CMD_ACK       16'h4141
`define SFCP_CMD_NAK       16'h414e
`define SFCP_CMD_SET_TASK  16'h004b
`define SFCP_SET_TASK_CNT  16'h0002
// header is 15 words; count is the last
`define SFCP_HDR_WORDS     4'hf
`define SFCP_IDX_CMD       4'h3
`define SFCP_IDX_TRANS     4'h7
`define SFCP_IDX_COUNT     4'he
// fieldbus address
`define SFCP_ADDR_DEFAULT  7'h7e
// slowed refresh while config tool attached
`define SFCP_SLOW_MS       200
`define SFCP_CLK_KHZ       100000
// device modes
`define SFCP_MODE_DETECT   2'h0
`define SFCP_MODE_MENU     2'h1
`define SFCP_MODE_CMD      2'h2
`endif

// ---- hdl/sfcp_skid_buffer.v ----
// sfcp_skid_buffer.v: two-entry buffer for 16-bit reply words
// assumes the drain side may stall at any time
`timescale 1ns/1ps
`default_nettype none
module sfcp_skid_buffer #(
   parameter WIDTH = 16
) (
   // clock and reset
   input  wire             mclk,
   input  wire             reset_n,
   // fill side
   input  wire             inValid,
   output wire             inReady,
   input  wire [WIDTH-1:0] inData,
   // drain side
   output wire             outValid,
   input  wire             outReady,
   output wire [WIDTH-1:0] outData
);
   reg [WIDTH-1:0] mem_r [0:1];
   reg             wrPtr_r;
   reg             rdPtr_r;
   reg [1:0]       count_r;
   wire            push;
   wire            pop;

   assign inReady  = (count_r != 2'h2);
   assign outValid = (count_r != 2'h0);
   assign outData  = mem_r[rdPtr_r];
   assign push     = inValid & inReady;
   assign pop      = outValid & outReady;

   ////////////////////////////////////////////////////////////////////////
   // pointers and storage; full refuses the writer so no word is lost
   always @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         wrPtr_r  <= 1'b0;
         rdPtr_r  <= 1'b0;
         count_r  <= 2'h0;
         mem_r[0] <= {WIDTH{1'b0}};
         mem_r[1] <= {WIDTH{1'b0}};
      end
      else
      begin
         if (push)
         begin
            mem_r[wrPtr_r] <= inData;
            wrPtr_r        <= ~wrPtr_r;
         end
         if (pop)
            rdPtr_r <= ~rdPtr_r;
         if (push & ~pop)
            count_r <= count_r + 2'h1;
         else if (pop & ~push)
            count_r <= count_r - 2'h1;
      end
   end
endmodule // sfcp_skid_buffer
`default_nettype wire

// ---- bench/sfcp_reply_sink.sv ----
// sfcp_reply_sink.sv: host side that drains reply words
// assumes one mclk; stall lets one word in four through
`timescale 1ns/1ps
`default_nettype none
module sfcp_reply_sink (
   // clock
   input wire logic        mclk,
   // reply stream
   input wire logic        txValid,
   input wire logic [15:0] txWord,
   output logic            txReady,
   // slow host when high
   input wire logic        stall
);
   logic [15:0] words[$];
   logic [1:0]  phase = 2'h0;

   // ready is decoded from the phase flop and the stall input, so it moves just after an edge or when stall does
   assign txReady = !stall || (phase == 2'h3);

   // take whole 16-bit words only, never split bytes
   always @(posedge mclk)
   begin
      phase <= phase + 2'h1;
      if (txValid && txReady)
         words.push_back(txWord);
   end
endmodule // sfcp_reply_sink
`default_nettype wire

// ---- bench/sfcp_command_port_asserts.sv ----
// sfcp_command_port_asserts.sv: port checker for the command port
// assumes bind onto sfcp_command_port, one mclk domain
`timescale 1ns/1ps
`default_nettype none
module sfcp_command_port_asserts (
   // clock and reset
   input wire logic         mclk,
   input wire logic         reset_n,
   // telegram stream
   input wire logic         rxValid,
   input wire logic         txValid,
   input wire logic         txReady,
   input wire logic [15:0]  txWord,
   // fieldbus and sensor
   input wire logic         fbTaskStrobe,
   input wire logic [3:0]   fbTaskNum,
   input wire logic         fbAddrStrobe,
   input wire logic [6:0]   fbAddrNew,
   input wire logic [1:0]   sensorMode,
   input wire logic         toolAttached,
   input wire logic         scanDone,
   input wire logic [15:0]  scanNum,
   input wire logic         localAddrStrobe,
   input wire logic [6:0]   localAddr,
   // results
   input wire logic         nvWrite,
   input wire logic [6:0]   nvWriteAddr,
   input wire logic [6:0]   slaveAddr,
   input wire logic         taskLoad,
   input wire logic [3:0]   taskSel,
   input wire logic [207:0] procData
);
   logic [3:0] wordIdx_r;
   logic [3:0] wordIdx_nxt;

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!reset_n);

   // position inside a 15-word reply, counted on accepted words
   assign wordIdx_nxt = (wordIdx_r == 4'he) ? 4'h0 : wordIdx_r + 4'h1;
   always_ff @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
         wordIdx_r <= 4'h0;
      else if (txValid && txReady)
         wordIdx_r <= wordIdx_nxt;
   end

   sequence sAddrOk;
      fbAddrStrobe && slaveAddr == 7'h7e && fbAddrNew < 7'h7e;
   endsequence
   sequence sWordHeld;
      txValid && $stable(txWord);
   endsequence

   chk_reply_start: assert property (txValid && wordIdx_r < 4'h2 |-> txWord == 16'hffff)
      else $error("reply start word wrong");
   chk_reply_code: assert property (txValid && wordIdx_r == 4'h3 |->
      txWord == 16'h4141 || txWord == 16'h414e)
      else $error("reply code wrong");
   chk_reply_pad: assert property (txValid &&
      !(wordIdx_r inside {4'h0, 4'h1, 4'h3, 4'h7}) |-> txWord == 16'h0000)
      else $error("reply padding not zero");
   chk_word_held: assert property (txValid && !txReady |=> sWordHeld)
      else $error("reply word lost under stall");
   chk_menu_freeze: assert property (sensorMode == 2'h1 [*2] |=> $stable(procData))
      else $error("process data moved in menu mode");
   chk_cmd_freeze: assert property (sensorMode == 2'h2 [*2] |=> $stable(procData))
      else $error("process data moved in command mode");
   chk_scan_update: assert property (scanDone && sensorMode == 2'h0 &&
      !toolAttached |=> procData[207:192] == $past(scanNum))
      else $error("scan number not reported");
   chk_addr_take: assert property (sAddrOk |=> nvWrite && slaveAddr == $past(fbAddrNew))
      else $error("assigned address not taken");
   chk_local_store: assert property (localAddrStrobe && !fbAddrStrobe |=>
      nvWrite && nvWriteAddr == $past(localAddr) && $stable(slaveAddr))
      else $error("local address handled wrongly");
   chk_bus_task: assert property (fbTaskStrobe && sensorMode == 2'h0 &&
      !toolAttached && !rxValid |=> taskLoad && taskSel == $past(fbTaskNum))
      else $error("bus task not loaded");
endmodule // sfcp_command_port_asserts

bind sfcp_command_port sfcp_command_port_asserts i_chk (.*);
`default_nettype wire

// ---- bench/testbench.sv ----
// testbench.sv: self-checking bench of the command port
// assumes the reply sink model and the bound port checker
`timescale 1ns/1ps
`default_nettype none
module testbench;
   // stimulus
   logic         mclk = 1'b0, reset_n = 1'b0, stall = 1'b1, rxValid = 1'b0, rxLast = 1'b0;
   logic         fbBaudLock = 1'b0, fbTaskStrobe = 1'b0, fbAddrStrobe = 1'b0;
   logic         pinTaskStrobe = 1'b0, toolAttached = 1'b0, scanDone = 1'b0;
   logic         nvAddrValid = 1'b0, localAddrStrobe = 1'b0;
   logic [15:0]  rxWord = 16'h0, scanNum = 16'h0, awResult = 16'h8001;
   logic [3:0]   fbTaskNum = 4'h0, pinTaskNum = 4'h0;
   logic [6:0]   fbAddrNew = 7'h0, nvAddr = 7'h0, localAddr = 7'h0;
   logic [1:0]   sensorMode = 2'h0;
   logic [7:0]   sensorInfo = 8'h5a, sensorState = 8'h21, logicResult = 8'h3c;
   logic [143:0] awHits = {9{16'h0123}};
   // observed
   logic         txValid, txReady, nvWrite, taskLoad, taskSave, fbActive;
   logic [15:0]  txWord;
   logic [6:0]   nvWriteAddr, slaveAddr;
   logic [3:0]   taskSel;
   logic [207:0] procData;
   int           mismatches = 0, checks = 0;

   // short refresh period keeps the slow-tool case brief
   sfcp_command_port #(.SLOW_CYCLES(20)) i_dut (.*);
   sfcp_reply_sink i_sink (.*);

   always #5 mclk = ~mclk;

   task automatic step(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask
   task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
      checks++;
      if (exp !== got)
      begin
         $display("ERROR %s expected %h seen %h", nm, exp, got);
         mismatches++;
      end
   endtask
   task automatic summarize;
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic waitLoad(input string nm);
      for (int k = 0; k < 8 && taskLoad !== 1'b1; k++)
         step(1);
      chk(nm, 16'h1, {15'h0, taskLoad});
      if (taskLoad !== 1'b1)
         summarize(); // a lost load ends the run
   endtask
   // header then user words, one a cycle, last marked
   task automatic send(input logic [15:0] cmd, cnt, u0, u1, input int nu);
      for (int i = 0; i < 15 + nu; i++)
      begin
         rxWord = (i < 2) ? 16'hffff : (i == 3) ? cmd : (i == 14) ? cnt :
                  (i == 15) ? u0 : (i == 16) ? u1 : 16'h0;
         rxLast = (i == 14 + nu);
         rxValid = 1'b1;
         step(1);
      end
      rxValid = 1'b0;
      rxLast = 1'b0;
   endtask
   task automatic reply(input logic [15:0] code, cmd);
      logic [15:0] e;
      for (int k = 0; k < 200 && i_sink.words.size() < 15; k++)
         step(1);
      if (i_sink.words.size() < 15)
      begin
         chk("reply count", 16'hf, 16'h0);
         summarize();
      end
      else
      begin
         for (int i = 0; i < 15; i++)
         begin
            e = (i < 2) ? 16'hffff : (i == 3) ? code : (i == 7) ? cmd : 16'h0;
            chk("reply word", e, i_sink.words[i]);
         end
         i_sink.words.delete();
      end
   endtask
   task automatic addr(input logic [6:0] a, input logic loc);
      fbAddrNew = a;
      localAddr = a;
      fbAddrStrobe = !loc;
      localAddrStrobe = loc;
      step(1);
      fbAddrStrobe = 1'b0;
      localAddrStrobe = 1'b0;
      step(2);
   endtask
   // freeze in menu and command mode, then live detection traffic
   task automatic tModes;
      logic [15:0] held;
      int hits;
      fbBaudLock = 1'b1;
      fbTaskNum = 4'h9;
      for (int m = 1; m < 4; m++)
      begin
         sensorMode = (m == 3) ? 2'h0 : m[1:0];
         held = procData[207:192];
         scanNum = scanNum + 16'h0101;
         scanDone = 1'b1;
         fbTaskStrobe = 1'b1;
         step(1);
         scanDone = 1'b0;
         fbTaskStrobe = 1'b0;
         hits = 0;
         for (int k = 0; k < 3; k++)
         begin
            hits += (taskLoad === 1'b1);
            step(1);
         end
         chk("bus active", 16'h1, {15'h0, fbActive});
         chk("frozen scan", (m == 3) ? scanNum : held, procData[207:192]);
         chk("bus task", (m == 3) ? 16'h1 : 16'h0, hits[15:0]);
      end
      chk("bus task number", 16'h9, {12'h0, taskSel});
      chk("sensor bytes", 16'h5a21, procData[191:176]);
   endtask
   task automatic tSlow;
      logic [15:0] last;
      int ups;
      toolAttached = 1'b1;
      scanDone = 1'b1;
      step(2);
      ups = 0;
      last = procData[207:192];
      repeat (40)
      begin
         scanNum = scanNum + 16'h1;
         step(1);
         ups += (procData[207:192] !== last);
         last = procData[207:192];
      end
      chk("slow refresh", 16'h2, ups[15:0]);
      toolAttached = 1'b0;
      scanDone = 1'b0;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      step(6);
      reset_n = 1'b1;
      step(2);
      chk("factory address", 16'h7e, {9'h0, slaveAddr});
      send(16'h004b, 16'h0002, 16'h000f, 16'h0001, 2);
      waitLoad("host task load");
      chk("host task", 16'hf, {12'h0, taskSel});
      chk("save flag", 16'h1, {15'h0, taskSave});
      reply(16'h4141, 16'h004b);
      send(16'h1234, 16'h0000, 16'h0, 16'h0, 0);
      reply(16'h414e, 16'h1234);
      send(16'h004b, 16'h0002, 16'h0010, 16'h0, 2);
      chk("refused task load", 16'h0, {15'h0, taskLoad});
      chk("task kept", 16'hf, {12'h0, taskSel});
      reply(16'h414e, 16'h004b);
      tModes();
      tSlow();
      pinTaskNum = 4'hc;
      pinTaskStrobe = 1'b1;
      step(1);
      waitLoad("pin task load");
      chk("pin task", 16'hc, {12'h0, taskSel});
      pinTaskStrobe = 1'b0;
      addr(7'h7e, 1'b0);
      chk("address kept", 16'h7e, {9'h0, slaveAddr});
      addr(7'h05, 1'b0);
      chk("address taken", 16'h05, {9'h0, nvWriteAddr});
      addr(7'h03, 1'b0);
      chk("address locked", 16'h05, {9'h0, slaveAddr});
      addr(7'h09, 1'b1);
      chk("local stored", 16'h09, {9'h0, nvWriteAddr});
      chk("local pending", 16'h05, {9'h0, slaveAddr});
      nvAddr = 7'h09;
      nvAddrValid = 1'b1;
      reset_n = 1'b0;
      step(2);
      reset_n = 1'b1;
      step(2);
      chk("after power on", 16'h09, {9'h0, slaveAddr});
      summarize();
   end
endmodule // testbench
`default_nettype wire
